// *** hdl/lvs_pkg.sv ***
package lvs_pkg;

  // ***************************************************
  // Register port shape
  // ***************************************************
  localparam int LVS_ADDR_W = 6;   // Register address width
  localparam int LVS_DATA_W = 16;  // Register data width

  typedef logic [LVS_ADDR_W-1:0] lvs_addr_t;  // Register address
  typedef logic [LVS_DATA_W-1:0] lvs_data_t;  // Register data word

  // One register access from the serial interface core
  typedef struct packed {
    logic wr;          // Write strobe, one cycle
    logic rd;          // Read strobe, one cycle
    lvs_addr_t addr;   // Register address
    lvs_data_t wdata;  // Write data, low bits used
  } lvs_reg_req_s;

  // Read answer
  typedef struct packed {
    logic rvalid;      // Read data valid, one cycle
    lvs_data_t rdata;  // Read data
  } lvs_reg_rsp_s;

  // ***************************************************
  // Register addresses
  // ***************************************************
  localparam lvs_addr_t ADDR_MODE = 6'h09;        // Mode register
  localparam lvs_addr_t ADDR_IRQ_EN = 6'h0a;      // Interrupt enable
  localparam lvs_addr_t ADDR_STATUS = 6'h0b;      // Status, plain read
  localparam lvs_addr_t ADDR_STATUS_CLR = 6'h0c;  // Status with reset
  localparam lvs_addr_t ADDR_CH1_OFS = 6'h0d;     // Channel one offset control
  localparam lvs_addr_t ADDR_ZX_TOUT = 6'h1d;     // Zero-cross timeout reload
  localparam lvs_addr_t ADDR_SAG_CYC = 6'h1e;     // Sag cycle limit
  localparam lvs_addr_t ADDR_SAG_LVL = 6'h1f;     // Sag threshold level
  localparam lvs_addr_t ADDR_PERIOD = 6'h27;      // Line period

  // ***************************************************
  // Field positions and reset values
  // ***************************************************
  localparam int STAT_SAG_BIT = 1;     // Sag event flag
  localparam int STAT_ZERO_CROSS_TIMEOUT_FLAG_BIT = 3;    // Zero-cross timeout flag
  localparam int STAT_ZX_BIT = 4;      // Zero-cross flag, idles high
  localparam int MODE_SAG_OUTPUT_DISABLE_BIT = 3;  // Sag output disable
  localparam int CH1_INTEG_BIT = 7;    // Integrator enable

  localparam lvs_data_t STATUS_RESET = 16'h0010;  // Zero-cross flag idles at one
  localparam lvs_data_t MODE_RESET = 16'h0000;    // Sag pin enabled
  localparam lvs_data_t IRQ_EN_RESET = 16'h0000;  // All sources masked
  localparam logic [7:0] CH1_OFS_RESET = 8'h00;   // Integrator off
  localparam logic [11:0] ZX_TOUT_RESET = 12'hfff;  // Longest timeout
  localparam logic [7:0] SAG_LVL_RESET = 8'h00;   // Sag detection at zero
  localparam logic [7:0] SAG_CYC_RESET = 8'h04;   // Three full cycles

  // ***************************************************
  // Timing in master clock cycles
  // ***************************************************
  localparam int ZX_TICK_CYC = 128;   // Timeout decrement interval
  localparam int PER_TICK_CYC = 8;    // Period count resolution
  localparam logic [14:0] PER_MAX = 15'h7fff;  // Period saturates, msb stays zero

endpackage : lvs_pkg

// *** hdl/lvs_lowpass.sv ***
`timescale 1ns/1ps
`default_nettype none

// Single-pole smoothing filter on the voltage channel samples.
module lvs_lowpass #(
  parameter int SHIFT = 5  // Pole position as a power of two
) (
  input wire logic clk,                 // Master clock
  input wire logic rstn,                // Asynchronous reset, active low
  input wire logic in_vld,              // Raw sample strobe
  input wire logic [15:0] in_sample,    // Raw signed sample
  output logic out_vld,                 // Filtered sample strobe
  output logic [15:0] out_sample        // Filtered signed sample
);

  // ***************************************************
  // Elaboration check
  // ***************************************************
  if (SHIFT < 1 || SHIFT > 8) begin : g_bad_shift
    $error("lvs_lowpass: SHIFT out of range");
  end

  typedef struct packed {
    logic signed [23:0] acc;  // Output with eight fraction bits
    logic vld;                // Output strobe
  } lvs_lp_state_s;

  lvs_lp_state_s st_q;  // Registered state
  lvs_lp_state_s st_d;  // Next state

  logic signed [24:0] diff;  // Input minus output
  logic signed [24:0] step;  // Scaled correction

  // ***************************************************
  // Filter update
  // ***************************************************
  // Extra fraction bits keep the pole free of dead band at small steps
  always_comb begin
    st_d = st_q;
    diff = $signed({in_sample[15], in_sample, 8'h00}) - $signed({st_q.acc[23], st_q.acc});
    step = diff >>> SHIFT;
    st_d.vld = in_vld;
    if (in_vld) begin  // Move one step toward the new sample
      st_d.acc = st_q.acc + step[23:0];
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_vld = st_q.vld;
  assign out_sample = st_q.acc[23:8];

endmodule // lvs_lowpass

`default_nettype wire

// *** hdl/lvs_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module lvs_top
  import lvs_pkg::*;
#(
  parameter int LP_SHIFT = 5  // Voltage filter pole as a power of two
) (
  input wire logic clk,                    // Master clock
  input wire logic rstn,                   // Asynchronous reset, active low
  input wire lvs_pkg::lvs_reg_req_s req,   // Register access from serial core
  output lvs_pkg::lvs_reg_rsp_s rsp,       // Register read answer
  input wire logic v_vld,                  // Voltage sample strobe
  input wire logic [15:0] v_sample,        // Voltage sample, signed
  input wire logic supply_low,             // Supply monitor, asynchronous
  output logic zero_cross_out,             // Zero-cross output pin level
  output logic sag_n,                      // Sag pin, active low
  output logic irq_n,                      // Interrupt pin, active low
  output logic integ_en,                   // Channel one integrator enable
  output logic accum_en                    // Energy accumulation allowed
);
  import lvs_pkg::*;

  // ***************************************************
  // Elaboration check
  // ***************************************************
  if (ZX_TICK_CYC != 128 || PER_TICK_CYC != 8) begin : g_bad_tick
    $error("lvs_top: divider widths assume 128 and 8");
  end

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    logic [6:0] zx_div;       // Timeout tick divider
    logic [2:0] per_div;      // Period tick divider
    logic [11:0] zx_cnt;      // Running timeout count
    logic [11:0] zx_reload;   // Programmed timeout
    logic [14:0] per_raw;     // Period count in progress
    logic [18:0] per_filt;    // Smoothed period, four fraction bits
    logic per_seen;           // First positive crossing seen
    logic per_have;           // One full period measured
    lvs_data_t mode;          // Mode register
    lvs_data_t irq_en;        // Interrupt enable
    lvs_data_t status;        // Interrupt status
    logic [7:0] ch1_ofs;      // Channel one offset control
    logic [7:0] sag_lvl;      // Sag threshold
    logic [7:0] sag_cyc;      // Sag cycle limit
    logic [7:0] sag_run;      // Consecutive low cycles
    logic cyc_low;            // Whole current cycle below threshold
    logic sag_low;            // Sag condition latched
    logic tout_low;           // Timeout condition latched
    logic prev_pos;           // Polarity of last filtered sample
    logic zx_out;             // Zero-cross pin level
    logic [2:0] sup_sync;     // Supply monitor synchroniser
    logic sup_low;            // Accepted supply state
    logic sag_pin_n;          // Sag pin level
    logic rvalid;             // Read answer strobe
    lvs_data_t rdata;         // Read answer data
  } lvs_state_s;

  lvs_state_s st_q;  // Registered state
  lvs_state_s st_d;  // Next state

  // Reset image of the whole state
  localparam lvs_state_s ST_RESET = '{
    zx_div: '0, per_div: '0, zx_cnt: ZX_TOUT_RESET, zx_reload: ZX_TOUT_RESET,
    per_raw: '0, per_filt: '0, per_seen: 1'b0, per_have: 1'b0,
    mode: MODE_RESET, irq_en: IRQ_EN_RESET, status: STATUS_RESET,
    ch1_ofs: CH1_OFS_RESET, sag_lvl: SAG_LVL_RESET, sag_cyc: SAG_CYC_RESET,
    sag_run: '0, cyc_low: 1'b1, sag_low: 1'b0, tout_low: 1'b0,
    prev_pos: 1'b0, zx_out: 1'b0, sup_sync: '0, sup_low: 1'b0,
    sag_pin_n: 1'b1, rvalid: 1'b0, rdata: '0
  };

  // ***************************************************
  // Filtered voltage channel
  // ***************************************************
  logic f_vld;         // Filtered sample strobe
  logic [15:0] f_smp;  // Filtered sample

  lvs_lowpass #(
    .SHIFT(LP_SHIFT)
  ) u_voltage_lowpass (
    .clk(clk),
    .rstn(rstn),
    .in_vld(v_vld),
    .in_sample(v_sample),
    .out_vld(f_vld),
    .out_sample(f_smp)
  );

  // ***************************************************
  // Helper functions
  // ***************************************************
  // Register address match, used by both write and read decode
  function automatic logic hit(input lvs_reg_req_s r, input lvs_addr_t a);
    hit = (r.addr == a);
  endfunction

  // Top byte of the doubled magnitude; the most negative code saturates
  function automatic logic [7:0] mag_byte(input logic [15:0] s);
    logic [15:0] m;
    m = s[15] ? (16'h0000 - s) : s;
    if (m[15]) begin
      m = 16'h7fff;
    end
    mag_byte = m[14:7];
  endfunction

  // ***************************************************
  // Combinational next state
  // ***************************************************
  logic now_pos;        // Filtered sample polarity
  logic cross_up;       // Positive-going crossing
  logic cross_dn;       // Negative-going crossing
  logic cross_any;      // Any crossing
  logic zx_tick;        // One pulse per 128 clocks
  logic per_tick;       // One pulse per 8 clocks
  logic [7:0] lvl_byte; // Compared magnitude byte
  logic below;          // Sample below threshold
  logic above;          // Sample above threshold
  logic tout_evt;       // Timeout reached zero
  logic sag_evt;        // Sag limit reached
  logic clr_rd;         // Status-with-reset read
  logic [19:0] per_new; // Smoothing sum
  lvs_data_t evt_mask;  // Flags set this cycle

  always_comb begin
    st_d = st_q;
    now_pos = ~f_smp[15];
    cross_up = f_vld && now_pos && !st_q.prev_pos;
    cross_dn = f_vld && !now_pos && st_q.prev_pos;
    cross_any = cross_up || cross_dn;
    zx_tick = (st_q.zx_div == 7'(ZX_TICK_CYC - 1));
    per_tick = (st_q.per_div == 3'(PER_TICK_CYC - 1));
    lvl_byte = mag_byte(f_smp);
    below = f_vld && (st_q.sag_lvl > lvl_byte);
    above = f_vld && (lvl_byte > st_q.sag_lvl);
    tout_evt = 1'b0;
    sag_evt = 1'b0;
    clr_rd = req.rd && hit(req, ADDR_STATUS_CLR);
    per_new = '0;
    evt_mask = '0;

    // Dividers give the slow enables
    st_d.zx_div = zx_tick ? '0 : st_q.zx_div + 7'h01;
    st_d.per_div = per_tick ? '0 : st_q.per_div + 3'h1;

    // Supply monitor: a change counts once stages two and three agree
    st_d.sup_sync = {st_q.sup_sync[1:0], supply_low};
    if (st_q.sup_sync[1] == st_q.sup_sync[2]) begin
      st_d.sup_low = st_q.sup_sync[2];
    end

    // Zero-cross pin follows polarity of the filtered voltage
    if (f_vld) begin
      st_d.prev_pos = now_pos;
    end
    if (cross_up) begin
      st_d.zx_out = 1'b1;
    end else if (cross_dn) begin
      st_d.zx_out = 1'b0;
    end

    // Timeout: reload on crossing, else count down and stop at zero
    if (cross_any) begin
      st_d.zx_cnt = st_q.zx_reload;
      st_d.tout_low = 1'b0;
    end else if (zx_tick && st_q.zx_cnt != '0) begin
      st_d.zx_cnt = st_q.zx_cnt - 12'h001;
      tout_evt = (st_q.zx_cnt == 12'h001);
    end
    if (tout_evt) begin
      st_d.tout_low = 1'b1;
      evt_mask[STAT_ZERO_CROSS_TIMEOUT_FLAG_BIT] = 1'b1;
    end

    // Period: count in units of eight clocks between rising crossings
    if (cross_up) begin
      st_d.per_raw = '0;
      st_d.per_seen = 1'b1;
      if (st_q.per_seen && !st_q.per_have) begin
        st_d.per_filt = {st_q.per_raw, 4'h0};
        st_d.per_have = 1'b1;
      end else if (st_q.per_seen) begin
        // Sixteen-step smoothing; fraction bits hold the jitter to one count
        per_new = {1'b0, st_q.per_filt} + {5'h00, st_q.per_raw} - {5'h00, st_q.per_filt[18:4]};
        st_d.per_filt = per_new[18:0];
      end
    end else if (per_tick && st_q.per_raw != PER_MAX) begin
      st_d.per_raw = st_q.per_raw + 15'h0001;
    end

    // Sag: a cycle counts low if no sample in it reached the threshold
    if (f_vld && !below) begin
      st_d.cyc_low = 1'b0;
    end
    if (cross_up) begin
      st_d.cyc_low = 1'b1;
      if (st_q.cyc_low && st_q.per_seen) begin
        if (st_q.sag_run != 8'hff) begin
          st_d.sag_run = st_q.sag_run + 8'h01;
        end
        // Fires once, on the cycle that makes the run equal limit minus one
        sag_evt = (8'(st_q.sag_run + 8'h01) == 8'(st_q.sag_cyc - 8'h01));
      end else begin
        st_d.sag_run = '0;
      end
    end
    if (sag_evt) begin
      st_d.sag_low = 1'b1;
      evt_mask[STAT_SAG_BIT] = 1'b1;
    end else if (above) begin
      st_d.sag_low = 1'b0;
      st_d.sag_run = '0;
    end

    // Sag pin: supply inactive overrides the disable bit
    st_d.sag_pin_n = !(st_d.sup_low ||
      (!st_q.mode[MODE_SAG_OUTPUT_DISABLE_BIT] && (st_d.sag_low || st_d.tout_low)));

    // Register writes
    if (req.wr) begin
      if (hit(req, ADDR_MODE)) begin
        st_d.mode = req.wdata;
      end
      if (hit(req, ADDR_IRQ_EN)) begin
        st_d.irq_en = req.wdata;
      end
      if (hit(req, ADDR_CH1_OFS)) begin
        st_d.ch1_ofs = req.wdata[7:0];
      end
      if (hit(req, ADDR_ZX_TOUT)) begin
        st_d.zx_reload = req.wdata[11:0];
      end
      if (hit(req, ADDR_SAG_CYC)) begin
        st_d.sag_cyc = req.wdata[7:0];
      end
      if (hit(req, ADDR_SAG_LVL)) begin
        st_d.sag_lvl = req.wdata[7:0];
      end
    end

    // Status: a read with reset restores defaults, events set afterwards
    if (clr_rd) begin
      st_d.status = STATUS_RESET;
    end
    st_d.status = st_d.status | evt_mask;
    if (cross_any) begin
      st_d.status[STAT_ZX_BIT] = 1'b0;
    end

    // Register reads answer one cycle after the strobe
    st_d.rvalid = req.rd;
    st_d.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        ADDR_MODE: begin
          st_d.rdata = st_q.mode;
        end
        ADDR_IRQ_EN: begin
          st_d.rdata = st_q.irq_en;
        end
        ADDR_STATUS, ADDR_STATUS_CLR: begin
          st_d.rdata = st_q.status;
        end
        ADDR_CH1_OFS: begin
          st_d.rdata = {8'h00, st_q.ch1_ofs};
        end
        ADDR_ZX_TOUT: begin
          st_d.rdata = {4'h0, st_q.zx_reload};
        end
        ADDR_SAG_CYC: begin
          st_d.rdata = {8'h00, st_q.sag_cyc};
        end
        ADDR_SAG_LVL: begin
          st_d.rdata = {8'h00, st_q.sag_lvl};
        end
        ADDR_PERIOD: begin
          st_d.rdata = {1'b0, st_q.per_filt[18:4]};
        end
        default: begin
          st_d.rdata = '0;  // Unmapped reads return zero
        end
      endcase
    end
  end

  // ***************************************************
  // State register
  // ***************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  // Zero-cross flag is active low in status, the others active high
  logic [2:0] pend;  // Enabled pending sources

  always_comb begin
    pend[0] = !st_q.status[STAT_ZX_BIT] && st_q.irq_en[STAT_ZX_BIT];
    pend[1] = st_q.status[STAT_ZERO_CROSS_TIMEOUT_FLAG_BIT] && st_q.irq_en[STAT_ZERO_CROSS_TIMEOUT_FLAG_BIT];
    pend[2] = st_q.status[STAT_SAG_BIT] && st_q.irq_en[STAT_SAG_BIT];
  end

  assign irq_n = ~|pend;
  assign zero_cross_out = st_q.zx_out;
  assign sag_n = st_q.sag_pin_n;
  assign integ_en = st_q.ch1_ofs[CH1_INTEG_BIT];
  assign accum_en = !st_q.sup_low;
  assign rsp = '{rvalid: st_q.rvalid, rdata: st_q.rdata};

endmodule // lvs_top

`default_nettype wire

// *** tb/lvs_props.sv ***
`timescale 1ns/1ps
`default_nettype none

// *****
// Port checker for the line supervisor
// *****
module lvs_props
  import lvs_pkg::*;
(
  input wire logic clk,                   // Master clock
  input wire logic rstn,                  // Reset, active low
  input wire lvs_pkg::lvs_reg_req_s req,  // Register access
  input wire lvs_pkg::lvs_reg_rsp_s rsp,  // Read answer
  input wire logic v_vld,                 // Sample strobe
  input wire logic [15:0] v_sample,       // Raw sample
  input wire logic supply_low,            // Supply monitor
  input wire logic zero_cross_out,        // Zero-cross pin
  input wire logic sag_n,                 // Sag pin, active low
  input wire logic irq_n,                 // Interrupt, active low
  input wire logic integ_en,              // Integrator enable
  input wire logic accum_en               // Accumulation allowed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Offset write, then a quiet cycle so a late enable still counts
  sequence s_ofs_wr;
    req.wr && req.addr == ADDR_CH1_OFS ##1 !req.wr;
  endsequence
  // Reload write followed by its read back one idle cycle later
  sequence s_tout_rdback;
    req.wr && req.addr == ADDR_ZX_TOUT ##2 req.rd && req.addr == ADDR_ZX_TOUT;
  endsequence
  // Clearing read with no crossing or expiry in flight
  sequence s_quiet_clr;
    req.rd && req.addr == ADDR_STATUS_CLR && sag_n && !v_vld ##0 !$past(v_vld);
  endsequence

  chk_integ_set: assert property (s_ofs_wr |=> integ_en == $past(req.wdata[7], 2))
    else $error("integrator enable does not follow offset bit");
  chk_integ_hold: assert property (!req.wr ##1 !req.wr |=> $stable(integ_en))
    else $error("integrator enable moved without a write");
  chk_rd_answer: assert property (req.rd |=> rsp.rvalid)
    else $error("read strobe got no answer");
  chk_rd_idle: assert property (!req.rd |=> !rsp.rvalid && rsp.rdata == '0)
    else $error("read answer without a read");
  chk_tout_back: assert property (s_tout_rdback |=> rsp.rdata == {4'h0, $past(req.wdata[11:0], 3)})
    else $error("timeout reload read back differs");
  chk_clr_irq: assert property (s_quiet_clr |=> irq_n)
    else $error("interrupt not released by clearing read");
  chk_zx_cause: assert property ($changed(zero_cross_out) |-> $past(v_vld, 2))
    else $error("zero-cross pin moved without a sample");
  chk_supply_off: assert property (supply_low [*5] |-> !accum_en && !sag_n)
    else $error("inactive supply not shown");
  chk_supply_on: assert property (!supply_low [*5] |-> accum_en)
    else $error("accumulation blocked with good supply");
  chk_period_msb: assert property (req.rd && req.addr == ADDR_PERIOD |=> !rsp.rdata[15])
    else $error("period msb set");
endmodule // lvs_props

bind lvs_top lvs_props u_props (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp),
  .v_vld(v_vld), .v_sample(v_sample), .supply_low(supply_low),
  .zero_cross_out(zero_cross_out), .sag_n(sag_n), .irq_n(irq_n),
  .integ_en(integ_en), .accum_en(accum_en));

`default_nettype wire

// *** tb/lvs_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// *****
// Host register master
// *****
// The device never stalls, so each strobe lives for exactly one edge
module lvs_host
  import lvs_pkg::*;
(
  input wire logic clk,                   // Master clock
  input wire lvs_pkg::lvs_reg_rsp_s rsp,  // Read answer
  output lvs_pkg::lvs_reg_req_s req       // Register access
);
  initial req = '0;

  // One register write
  task automatic wr(input lvs_addr_t a, input lvs_data_t d);
    // Cycle counts below two are never sent; the device cannot use them
    if (a == ADDR_SAG_CYC && d < 16'h0002) return;
    @(posedge clk);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req = '0;
  endtask

  // One register read; the clearing address retires pending events
  task automatic rd(input lvs_addr_t a, output lvs_data_t d);
    @(posedge clk);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    #1;
    req = '0;
    d = rsp.rdata;
  endtask
endmodule // lvs_host

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) \
  begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h exp %h", $time, (a), (e)); end end

module tb;
  import lvs_pkg::*;
  logic clk = 1'b0;             // Master clock
  logic rstn = 1'b0;            // Reset, active low
  logic v_vld = 1'b0;           // Sample strobe
  logic [15:0] v_sample = '0;   // Raw sample
  logic supply_low = 1'b0;      // Supply monitor
  lvs_reg_req_s req;            // Host access
  lvs_reg_rsp_s rsp;            // Read answer
  logic zero_cross_out, sag_n, irq_n, integ_en, accum_en;
  lvs_data_t rv;                // Last read value
  int num_errors = 0;           // Mismatches
  int n_checks = 0;             // Comparisons

  // Fast filter pole so a crossing lands within two samples
  lvs_top #(.LP_SHIFT(1)) DUT (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp),
    .v_vld(v_vld), .v_sample(v_sample), .supply_low(supply_low),
    .zero_cross_out(zero_cross_out), .sag_n(sag_n), .irq_n(irq_n),
    .integ_en(integ_en), .accum_en(accum_en));
  lvs_host host (.clk(clk), .rsp(rsp), .req(req));

  // *****
  // Stimulus helpers
  // *****
  initial forever #5 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Samples every other cycle keep the line period exact
  task automatic smp(input int n, input logic [15:0] s);
    repeat (n) begin
      @(posedge clk);
      #1;
      v_vld = 1'b1;
      v_sample = s;
      @(posedge clk);
      #1;
      v_vld = 1'b0;
    end
  endtask

  // Square line cycles of 32 clocks
  task automatic lines(input int n, input logic [15:0] a);
    repeat (n) begin
      smp(8, a);
      smp(8, -a);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // *****
  // Scenarios
  // *****
  task automatic t_reset();
    host.rd(ADDR_ZX_TOUT, rv);
    `CHK(rv, {4'h0, ZX_TOUT_RESET})
    `CHK(integ_en, 1'b0)
    host.wr(ADDR_CH1_OFS, 16'h0080);
    cyc(1);
    `CHK(integ_en, 1'b1)
    host.wr(ADDR_CH1_OFS, 16'h0000);
    cyc(1);
    `CHK(integ_en, 1'b0)
    host.rd(6'h3f, rv);
    `CHK(rv, 16'h0000)
  endtask

  task automatic t_supply();
    supply_low = 1'b1;
    cyc(6);
    `CHK({accum_en, sag_n}, 2'b00)
    supply_low = 1'b0;
    cyc(6);
    `CHK({accum_en, sag_n}, 2'b11)
  endtask

  task automatic t_zx();
    host.wr(ADDR_IRQ_EN, 16'h0010);
    smp(8, 16'hf000);
    host.rd(ADDR_STATUS_CLR, rv);
    `CHK(irq_n, 1'b1)
    smp(8, 16'h1000);
    cyc(3);
    `CHK(zero_cross_out, 1'b1)
    `CHK(irq_n, 1'b0)
    cyc(20);
    host.rd(ADDR_STATUS, rv);
    `CHK(rv[STAT_ZX_BIT], 1'b0)
    host.rd(ADDR_STATUS_CLR, rv);
    `CHK(irq_n, 1'b1)
    host.rd(ADDR_STATUS, rv);
    `CHK(rv, STATUS_RESET)
    smp(8, 16'hf000);
    cyc(3);
    `CHK({zero_cross_out, irq_n}, 2'b00)
    host.wr(ADDR_IRQ_EN, 16'h0000);
    `CHK(irq_n, 1'b1)
  endtask

  task automatic t_tout();
    int n;
    host.wr(ADDR_ZX_TOUT, 16'h0003);
    host.wr(ADDR_IRQ_EN, 16'h0008);
    smp(2, 16'h5000);
    n = 0;
    // Three ticks of 128 clocks, phase of the divider unknown
    while (sag_n === 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    if (n >= 600) begin
      num_errors++;
      final_report();
    end
    `CHK((n >= 250 && n <= 395), 1'b1)
    cyc(2);
    `CHK(irq_n, 1'b0)
    host.rd(ADDR_STATUS_CLR, rv);
    `CHK({rv[STAT_ZERO_CROSS_TIMEOUT_FLAG_BIT], sag_n}, 2'b10)
    host.wr(ADDR_IRQ_EN, 16'h0000);
    // Crossing alone must release the pin; the disable bit comes afterwards
    smp(2, 16'hb000);
    cyc(3);
    `CHK(sag_n, 1'b1)
    host.wr(ADDR_MODE, 16'h0008);
    cyc(400);
    `CHK({sag_n, irq_n}, 2'b11)
    host.rd(ADDR_STATUS_CLR, rv);
    `CHK(rv[STAT_ZERO_CROSS_TIMEOUT_FLAG_BIT], 1'b1)
    host.wr(ADDR_ZX_TOUT, 16'h0fff);
    host.rd(ADDR_ZX_TOUT, rv);
    `CHK(rv, 16'h0fff)
    host.wr(ADDR_MODE, 16'h0000);
    smp(2, 16'h5000);
  endtask

  task automatic t_sag();
    host.wr(ADDR_SAG_LVL, 16'h0020);
    host.wr(ADDR_SAG_CYC, 16'h0003);
    host.wr(ADDR_SAG_CYC, 16'h0001);
    host.wr(ADDR_IRQ_EN, 16'h0002);
    host.rd(ADDR_STATUS_CLR, rv);
    // Long run lets the smoothed period settle
    lines(80, 16'h3000);
    host.rd(ADDR_PERIOD, rv);
    `CHK((rv >= 16'h0003 && rv <= 16'h0005), 1'b1)
    host.rd(ADDR_SAG_CYC, rv);
    `CHK(rv, 16'h0003)
    smp(8, 16'hfc00);
    lines(1, 16'h0400);
    smp(2, 16'h0400);
    cyc(3);
    `CHK(sag_n, 1'b1)
    smp(6, 16'h0400);
    smp(8, 16'hfc00);
    smp(2, 16'h0400);
    cyc(3);
    `CHK({sag_n, irq_n}, 2'b00)
    host.rd(ADDR_STATUS_CLR, rv);
    `CHK(rv[STAT_SAG_BIT], 1'b1)
    smp(4, 16'h3000);
    cyc(3);
    `CHK(sag_n, 1'b1)
  endtask

  // *****
  // Main sequence and hang guard
  // *****
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_supply();
    t_zx();
    t_tout();
    t_sag();
    final_report();
  end

  initial begin
    #900us;
    num_errors++;
    final_report();
  end
endmodule // tb

`default_nettype wire
